/* File: verilog/lfc_params.svh */
`ifndef LFC_PARAMS_SVH
`define LFC_PARAMS_SVH
`define LFC_CLK_NS 8
`define LFC_TO_DEF_MIN_NS 25000
`define LFC_TO_DEF_MAX_NS 50000
`define LFC_TO_LONG_MIN_NS 100000
`define LFC_TO_LONG_MAX_NS 200000
`define LFC_CNT_W 4
`define LFC_QUOTA_W 8
`define LFC_XFER_W 6
`define LFC_FRAME_W 16
`endif

/* File: verilog/lfc_pkg.sv */
package lfc_pkg;
  typedef enum logic [2:0] {
    LFC_PS_DISABLED,
    LFC_PS_ENABLED,
    LFC_PS_CHECK,
    LFC_PS_READY,
    LFC_PS_OTHER
  } lfc_port_state_t;
  typedef enum logic [2:0] {
    LFC_FT_APPLICATION,
    LFC_FT_PRIVILEGED,
    LFC_FT_RESERVED,
    LFC_FT_CTL_LINK_RESET,
    LFC_FT_CTL_TOTAL_RESET,
    LFC_FT_CTL_ABS_RESET,
    LFC_FT_CTL_OTHER
  } lfc_frame_type_t;
  typedef enum logic [2:0] {
    LFC_CH_OTHER,
    LFC_CH_ACK,
    LFC_CH_RR,
    LFC_CH_NUL
  } lfc_char_t;
  typedef enum logic [1:0] {
    LFC_TX_IDLE,
    LFC_TX_SECOND
  } lfc_pair_state_t;
endpackage : lfc_pkg

/* File: verilog/lfc_cnt_if.sv */
`timescale 1ns/10ps
interface lfc_cnt_if #(parameter int W = 4);
  logic inc;
  logic dec;
  logic clr;
  logic [W-1:0] count;
  logic nonzero;
  modport ctl (output inc, output dec, output clr, input count, input nonzero);
  modport cnt (input inc, input dec, input clr, output count, output nonzero);
endinterface : lfc_cnt_if

/* File: verilog/lfc_flag_cnt.sv */
`timescale 1ns/10ps
module lfc_flag_cnt #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and value
  lfc_cnt_if.cnt c
);
  import lfc_pkg::*;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  initial
  begin
    if (W < 2) $error("lfc_flag_cnt: width too small");
  end
  // saturating both ways so a stray event cannot wrap the count
  always_comb
  begin
    cnt_next = cnt_reg;
    if (c.clr)
      cnt_next = '0;
    else if (c.inc && !c.dec && cnt_reg != {W{1'b1}})
      cnt_next = cnt_reg + 1'b1;
    else if (c.dec && !c.inc && cnt_reg != '0)
      cnt_next = cnt_reg - 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
  assign c.count = cnt_reg;
  assign c.nonzero = (cnt_reg != '0);
  never_below_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_reg == '0 && c.dec && !c.inc && !c.clr) |=> cnt_reg == '0)
    else $error("counter went below zero");
endmodule : lfc_flag_cnt

/* File: verilog/lfc_pair_rx.sv */
`timescale 1ns/10ps
module lfc_pair_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // received characters
  input wire logic rx_valid,
  input wire lfc_pkg::lfc_char_t rx_char,
  input wire lfc_pkg::lfc_char_t match_char,
  // results
  output logic pair_pulse,
  output logic lone_pulse
);
  import lfc_pkg::*;
  logic half_reg;
  logic half_next;
  // a first character followed by anything else is a lone one
  always_comb
  begin
    half_next = half_reg;
    pair_pulse = 1'b0;
    lone_pulse = 1'b0;
    if (rx_valid)
    begin
      if (rx_char == match_char)
      begin
        pair_pulse = half_reg;
        half_next = !half_reg;
      end
      else
      begin
        lone_pulse = half_reg;
        half_next = 1'b0;
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      half_reg <= 1'b0;
    else
      half_reg <= half_next;
  end
  pair_needs_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    pair_pulse |-> half_reg && rx_valid && rx_char == match_char)
    else $error("pair accepted without two characters");
endmodule : lfc_pair_rx

/* File: verilog/lfc_link_flow.sv */
`timescale 1ns/10ps
`include "lfc_params.svh"
// Overview of operation
// - ACK and RR travel as two identical adjacent characters; act only on whole pairs
// - ACK and RR are consumed at this port, never forwarded to another port
// - acknowledge every valid frame except total reset, reserved, absolute reset
// - received ACK pair releases the sent frame and decrements ack_outstanding_count
// - entering Disabled clears ack_outstanding_count and ack_owed_count
// - after closing flag of an acknowledged frame type increment ack_outstanding_count
// - default ACK time-out 25 to 50 us; then flag ACK error, start recovery
// - long-reach option uses a 100 to 200 us ACK time-out
// - hold closing flag sending NUL while ACK outstanding; time-out aborts frame
// - ACK pair with nothing outstanding or lone ACK is a protocol error
// - count owed ACK on valid closing flag in Ready, or link reset in Check
// - send an owed ACK pair at the earliest chance, then decrement the count
// - receiver buffers at least one whole frame before granting RR
// - entering Enabled increments rr_outstanding_count and rr_owed_count
// - start frame in Ready with no RR outstanding, or control frame in Enabled/Check/Ready
// - sent control field of credited frame increments, RR pair decrements rr_outstanding_count
// - send RR pair after current character when Ready, owed and buffer free
// - received control field of credited frame makes rr_owed_count nonzero; sent RR decrements
// - busy and idle thresholds are quotas times outstanding transfers
// - origination_counter counts originated frames, clears on token forward or reflect
// - only frames whose closing flag went out count; aborts do not
// - satisfied when counter reaches busy threshold or nothing to send holding token
// - originate holding token unsatisfied, or no forwarding and idle threshold above counter
// - unsatisfied port keeps the token until satisfied, then releases it and clears counter
module lfc_link_flow #(
  parameter int CNT_W = `LFC_CNT_W,
  parameter int QUOTA_W = `LFC_QUOTA_W,
  parameter int XFER_W = `LFC_XFER_W,
  parameter int FRAME_W = `LFC_FRAME_W,
  parameter int TO_DEF_NS = `LFC_TO_DEF_MIN_NS,
  parameter int TO_LONG_NS = `LFC_TO_LONG_MIN_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // port state and configuration
  input wire lfc_pkg::lfc_port_state_t port_state,
  input wire logic long_reach,
  input wire logic [QUOTA_W-1:0] busy_link_quota,
  input wire logic [QUOTA_W-1:0] idle_link_quota,
  input wire logic [XFER_W-1:0] xfers_outstanding,
  // received character stream
  input wire logic rx_char_valid,
  input wire lfc_pkg::lfc_char_t rx_char,
  input wire logic rx_ctl_field,
  input wire logic rx_end_flag,
  input wire logic rx_frame_valid,
  input wire lfc_pkg::lfc_frame_type_t rx_frame_type,
  input wire logic rx_buf_free,
  // transmit framer
  input wire logic tx_char_slot,
  input wire logic tx_ctl_field,
  input wire logic tx_crc_done,
  input wire logic tx_end_flag,
  input wire logic tx_abort_done,
  input wire lfc_pkg::lfc_frame_type_t tx_frame_type,
  input wire logic tx_originated,
  // insertion of flow characters
  output logic tx_insert,
  output lfc_pkg::lfc_char_t tx_insert_char,
  output logic tx_hold_flag,
  output logic tx_abort,
  output logic tx_release_frame,
  // frame start permission
  output logic may_start_frame,
  output logic may_start_control,
  // fairness token
  input wire logic token_held,
  input wire logic forward_pending,
  input wire logic have_app_frames,
  output logic token_release,
  output logic may_originate,
  output logic satisfied,
  output logic [FRAME_W-1:0] origination_counter,
  // errors toward link_error_recovery
  output logic ack_error_pulse,
  output logic protocol_error_pulse,
  output logic [CNT_W-1:0] ack_outstanding_count,
  output logic [CNT_W-1:0] ack_owed_count,
  output logic [CNT_W-1:0] rr_outstanding_count,
  output logic [CNT_W-1:0] rr_owed_count
);
  import lfc_pkg::*;
  localparam int TO_DEF_CYC = (TO_DEF_NS + `LFC_CLK_NS - 1) / `LFC_CLK_NS;
  localparam int TO_LONG_CYC = (TO_LONG_NS + `LFC_CLK_NS - 1) / `LFC_CLK_NS;
  localparam int TMR_W = $clog2(TO_LONG_CYC + 1);
  localparam int THR_W = QUOTA_W + XFER_W;
  initial
  begin
    if (CNT_W < 2 || QUOTA_W < 1 || XFER_W < 1 || FRAME_W < 2) $error("lfc: bad widths");
    if (TO_DEF_NS < `LFC_TO_DEF_MIN_NS || TO_DEF_NS > `LFC_TO_DEF_MAX_NS)
      $error("lfc: default time-out out of range");
    if (TO_LONG_NS < `LFC_TO_LONG_MIN_NS || TO_LONG_NS > `LFC_TO_LONG_MAX_NS)
      $error("lfc: long-reach time-out out of range");
  end

  lfc_cnt_if #(.W(CNT_W)) ack_out_if ();
  lfc_cnt_if #(.W(CNT_W)) ack_owe_if ();
  lfc_cnt_if #(.W(CNT_W)) rr_out_if ();
  lfc_cnt_if #(.W(CNT_W)) rr_owe_if ();
  lfc_flag_cnt #(.W(CNT_W)) u_ack_out (.clk(clk), .rst_n(rst_n), .c(ack_out_if));
  lfc_flag_cnt #(.W(CNT_W)) u_ack_owe (.clk(clk), .rst_n(rst_n), .c(ack_owe_if));
  lfc_flag_cnt #(.W(CNT_W)) u_rr_out (.clk(clk), .rst_n(rst_n), .c(rr_out_if));
  lfc_flag_cnt #(.W(CNT_W)) u_rr_owe (.clk(clk), .rst_n(rst_n), .c(rr_owe_if));

  // pair detection; the characters end here and are not handed on
  logic ack_pair;
  logic ack_lone;
  logic rr_pair;
  lfc_pair_rx u_ack_rx (
    .clk(clk), .rst_n(rst_n), .rx_valid(rx_char_valid), .rx_char(rx_char),
    .match_char(LFC_CH_ACK), .pair_pulse(ack_pair), .lone_pulse(ack_lone));
  lfc_pair_rx u_rr_rx (
    .clk(clk), .rst_n(rst_n), .rx_valid(rx_char_valid), .rx_char(rx_char),
    .match_char(LFC_CH_RR), .pair_pulse(rr_pair), .lone_pulse());

  // entry detection of Disabled and Enabled
  lfc_port_state_t state_reg;
  lfc_port_state_t state_next;
  logic enter_disabled;
  logic enter_enabled;
  always_comb
  begin
    state_next = port_state;
    enter_disabled = (port_state == LFC_PS_DISABLED) && (state_reg != LFC_PS_DISABLED);
    enter_enabled = (port_state == LFC_PS_ENABLED) && (state_reg != LFC_PS_ENABLED);
  end

  function automatic logic acked_type(input lfc_frame_type_t t);
    acked_type = !(t == LFC_FT_CTL_TOTAL_RESET || t == LFC_FT_RESERVED ||
                   t == LFC_FT_CTL_ABS_RESET);
  endfunction : acked_type

  function automatic logic credited_type(input lfc_frame_type_t t);
    credited_type = (t == LFC_FT_PRIVILEGED || t == LFC_FT_RESERVED ||
                     t == LFC_FT_APPLICATION);
  endfunction : credited_type

  // counter events
  logic rx_good_end;
  logic ready;
  always_comb
  begin
    ready = (port_state == LFC_PS_READY);
    rx_good_end = rx_end_flag && rx_frame_valid;
    ack_out_if.clr = enter_disabled;
    ack_out_if.inc = tx_end_flag && acked_type(tx_frame_type);
    ack_out_if.dec = ack_pair;
    ack_owe_if.clr = enter_disabled;
    ack_owe_if.inc = rx_good_end &&
      ((ready && acked_type(rx_frame_type)) ||
       (port_state == LFC_PS_CHECK && rx_frame_type == LFC_FT_CTL_LINK_RESET));
    rr_out_if.clr = 1'b0;
    rr_out_if.inc = enter_enabled ||
      (tx_ctl_field && credited_type(tx_frame_type));
    rr_out_if.dec = rr_pair;
    rr_owe_if.clr = 1'b0;
    rr_owe_if.inc = enter_enabled ||
      (rx_ctl_field && credited_type(rx_frame_type));
  end

  // pair transmitter; the ACK pair goes first, even inside a frame
  lfc_pair_state_t pst_reg;
  lfc_pair_state_t pst_next;
  lfc_char_t pch_reg;
  lfc_char_t pch_next;
  always_comb
  begin
    pst_next = pst_reg;
    pch_next = pch_reg;
    tx_insert = 1'b0;
    tx_insert_char = pch_reg;
    ack_owe_if.dec = 1'b0;
    rr_owe_if.dec = 1'b0;
    unique case (pst_reg)
      LFC_TX_IDLE:
      begin
        if (tx_char_slot && ack_owe_if.nonzero)
        begin
          tx_insert = 1'b1;
          tx_insert_char = LFC_CH_ACK;
          pch_next = LFC_CH_ACK;
          pst_next = LFC_TX_SECOND;
        end
        else if (tx_char_slot && ready && rr_owe_if.nonzero && rx_buf_free)
        begin
          tx_insert = 1'b1;
          tx_insert_char = LFC_CH_RR;
          pch_next = LFC_CH_RR;
          pst_next = LFC_TX_SECOND;
        end
      end
      LFC_TX_SECOND:
      begin
        if (tx_char_slot)
        begin
          tx_insert = 1'b1;
          pst_next = LFC_TX_IDLE;
          ack_owe_if.dec = (pch_reg == LFC_CH_ACK);
          rr_owe_if.dec = (pch_reg == LFC_CH_RR);
        end
      end
    endcase
  end

  // acknowledgment timer, restarted on each new outstanding frame
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic [TMR_W-1:0] tmr_limit;
  logic timeout;
  logic hold_reg;
  logic hold_next;
  always_comb
  begin
    tmr_limit = long_reach ? TMR_W'(TO_LONG_CYC) : TMR_W'(TO_DEF_CYC);
    timeout = ack_out_if.nonzero && (tmr_reg >= tmr_limit);
    tmr_next = tmr_reg;
    if (!ack_out_if.nonzero || ack_out_if.inc || ack_pair || timeout)
      tmr_next = '0;
    else
      tmr_next = tmr_reg + 1'b1;
    hold_next = hold_reg;
    if (tx_crc_done && ack_out_if.nonzero && !ack_pair)
      hold_next = 1'b1;
    else if (ack_pair || timeout || tx_abort_done || enter_disabled)
      hold_next = 1'b0;
    tx_hold_flag = hold_reg || (tx_crc_done && ack_out_if.nonzero && !ack_pair);
    tx_abort = hold_reg && timeout;
    ack_error_pulse = timeout;
    protocol_error_pulse = (ack_pair && !ack_out_if.nonzero) || ack_lone;
    tx_release_frame = ack_pair && ack_out_if.nonzero;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tmr_reg <= '0;
      hold_reg <= 1'b0;
      pst_reg <= LFC_TX_IDLE;
      pch_reg <= LFC_CH_OTHER;
      state_reg <= LFC_PS_DISABLED;
    end
    else
    begin
      tmr_reg <= tmr_next;
      hold_reg <= hold_next;
      pst_reg <= pst_next;
      pch_reg <= pch_next;
      state_reg <= state_next;
    end
  end

  // start permission
  always_comb
  begin
    may_start_frame = ready && !rr_out_if.nonzero;
    may_start_control = ready || port_state == LFC_PS_ENABLED ||
      port_state == LFC_PS_CHECK;
  end

  // fairness bookkeeping
  logic [THR_W-1:0] busy_thr;
  logic [THR_W-1:0] idle_thr;
  logic [FRAME_W-1:0] orig_reg;
  logic [FRAME_W-1:0] orig_next;
  always_comb
  begin
    busy_thr = THR_W'(busy_link_quota) * THR_W'(xfers_outstanding);
    idle_thr = THR_W'(idle_link_quota) * THR_W'(xfers_outstanding);
    satisfied = ({{THR_W{1'b0}}, orig_reg} >= {{FRAME_W{1'b0}}, busy_thr}) ||
      (token_held && !have_app_frames);
    token_release = token_held && satisfied;
    may_originate = (token_held && !satisfied) ||
      (!forward_pending &&
       ({{FRAME_W{1'b0}}, idle_thr} > {{THR_W{1'b0}}, orig_reg}));
    orig_next = orig_reg;
    if (token_release)
      orig_next = '0;
    else if (tx_end_flag && tx_originated && tx_frame_type == LFC_FT_APPLICATION &&
             orig_reg != {FRAME_W{1'b1}})
      orig_next = orig_reg + 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      orig_reg <= '0;
    else
      orig_reg <= orig_next;
  end

  assign origination_counter = orig_reg;
  assign ack_outstanding_count = ack_out_if.count;
  assign ack_owed_count = ack_owe_if.count;
  assign rr_outstanding_count = rr_out_if.count;
  assign rr_owed_count = rr_owe_if.count;

  disabled_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    enter_disabled |=> ack_outstanding_count == '0 && ack_owed_count == '0)
    else $error("disabled entry did not clear ack counts");
  lone_ack_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    ack_lone |-> protocol_error_pulse)
    else $error("lone ack not flagged");
  ack_pair_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pst_reg == LFC_TX_IDLE && tx_char_slot && ack_owe_if.nonzero) |->
      tx_insert && tx_insert_char == LFC_CH_ACK)
    else $error("owed ack not sent");
  start_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    may_start_frame |-> ready && rr_outstanding_count == '0)
    else $error("frame start while waiting for rr");
  abort_on_to_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_abort |-> ack_error_pulse ##1 !hold_reg)
    else $error("abort without time-out");
  rr_needs_buf_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_insert && pst_reg == LFC_TX_IDLE && tx_insert_char == LFC_CH_RR) |->
      ready && rx_buf_free)
    else $error("rr sent without buffer");
  token_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    token_release |=> origination_counter == '0)
    else $error("counter not cleared on release");
  abort_no_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_abort_done && !tx_end_flag && !token_release) |=>
      origination_counter == $past(origination_counter))
    else $error("aborted frame counted");
  release_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_release_frame && !ack_out_if.inc && !enter_disabled) |=>
      ack_outstanding_count == $past(ack_outstanding_count) - 1'b1)
    else $error("released frame left count standing");
  enabled_rr_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enter_enabled && !rr_pair && !rr_owe_if.dec && rr_outstanding_count != '1 &&
     rr_owed_count != '1) |=>
      rr_outstanding_count == $past(rr_outstanding_count) + 1'b1 &&
      rr_owed_count == $past(rr_owed_count) + 1'b1)
    else $error("enabled entry did not count rr");
  ctl_rr_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_ctl_field && tx_frame_type == LFC_FT_APPLICATION && !enter_enabled && !rr_pair &&
     rr_outstanding_count != '1) |=>
      rr_outstanding_count == $past(rr_outstanding_count) + 1'b1)
    else $error("sent control field not counted");
  owed_ack_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_good_end && ready && rx_frame_type == LFC_FT_APPLICATION && !ack_owe_if.dec &&
     ack_owed_count != '1) |=>
      ack_owed_count == $past(ack_owed_count) + 1'b1)
    else $error("valid frame not owed an ack");
endmodule : lfc_link_flow

/* File: tb/lfc_peer.sv */
`timescale 1ns/10ps
module lfc_peer
  import lfc_pkg::*;
(
  // clock
  input wire logic clk,
  // characters toward the port
  output logic rx_char_valid,
  output lfc_pkg::lfc_char_t rx_char,
  // characters from the port
  input wire logic tx_char_slot,
  input wire logic tx_insert,
  input wire lfc_pkg::lfc_char_t tx_insert_char,
  output logic [7:0] ack_chars,
  output logic [7:0] rr_chars
);
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char = LFC_CH_NUL;
    ack_chars = 8'h00;
    rr_chars = 8'h00;
  end
  // tally flow characters the port puts in its slots
  always @(posedge clk)
  begin
    if (tx_char_slot === 1'b1 && tx_insert === 1'b1 && tx_insert_char === LFC_CH_ACK)
      ack_chars <= ack_chars + 8'h01;
    if (tx_char_slot === 1'b1 && tx_insert === 1'b1 && tx_insert_char === LFC_CH_RR)
      rr_chars <= rr_chars + 8'h01;
  end
  // n copies back to back; cut breaks a pair with a data char
  task send(input lfc_char_t ch, input int n, input bit cut);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk);
      rx_char_valid <= 1'b1;
      rx_char <= ch;
    end
    if (cut)
    begin
      @(posedge clk);
      rx_char <= LFC_CH_OTHER;
    end
    @(posedge clk);
    rx_char_valid <= 1'b0;
    // idle line shows filler, never a stale flow char
    rx_char <= LFC_CH_NUL;
  endtask : send
endmodule : lfc_peer

/* File: tb/link_flow_control_fairness_tb.sv */
`timescale 1ns/10ps
module link_flow_control_fairness_tb;
  import lfc_pkg::*;
  logic clk, rst_n, long_reach, rx_ctl_field, rx_end_flag, rx_frame_valid;
  logic rx_buf_free, tx_char_slot, tx_ctl_field, tx_crc_done, tx_end_flag;
  logic tx_abort_done, tx_originated, token_held, forward_pending, have_app_frames;
  logic rx_char_valid, tx_insert, tx_hold_flag, tx_abort, tx_release_frame;
  logic may_start_frame, may_start_control, token_release, may_originate, satisfied;
  logic ack_error_pulse, protocol_error_pulse;
  logic [7:0] busy_link_quota, idle_link_quota, ack_chars, rr_chars;
  logic [5:0] xfers_outstanding;
  logic [15:0] origination_counter;
  logic [3:0] ack_outstanding_count, ack_owed_count, rr_outstanding_count, rr_owed_count;
  lfc_port_state_t port_state;
  lfc_char_t rx_char, tx_insert_char;
  lfc_frame_type_t rx_frame_type, tx_frame_type, ft;
  int fails, num_checks, n_rel, n_perr, n_aerr, n_abort, i, e, r;

  lfc_peer u_peer (.clk, .rx_char_valid, .rx_char, .tx_char_slot, .tx_insert, .tx_insert_char,
    .ack_chars, .rr_chars);
  lfc_link_flow u_dut (.clk, .rst_n, .port_state, .long_reach, .busy_link_quota,
    .idle_link_quota, .xfers_outstanding, .rx_char_valid, .rx_char, .rx_ctl_field, .rx_end_flag,
    .rx_frame_valid, .rx_frame_type, .rx_buf_free, .tx_char_slot, .tx_ctl_field, .tx_crc_done,
    .tx_end_flag, .tx_abort_done, .tx_frame_type, .tx_originated, .tx_insert, .tx_insert_char,
    .tx_hold_flag, .tx_abort, .tx_release_frame, .may_start_frame, .may_start_control,
    .token_held, .forward_pending, .have_app_frames, .token_release, .may_originate,
    .satisfied, .origination_counter, .ack_error_pulse, .protocol_error_pulse,
    .ack_outstanding_count, .ack_owed_count, .rr_outstanding_count, .rr_owed_count);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // one-cycle pulses are tallied at the edge that ends them
  always @(posedge clk)
  begin
    if (tx_release_frame === 1'b1) n_rel++;
    if (protocol_error_pulse === 1'b1) n_perr++;
    if (ack_error_pulse === 1'b1) n_aerr++;
    if (tx_abort === 1'b1) n_abort++;
  end

  task chk_bit(input string nm, input logic ev, input logic g);
    num_checks++;
    if (g !== ev)
    begin
      fails++;
      $display("BAD %s exp %0h got %0h", nm, ev, g);
    end
  endtask : chk_bit
  task chk_cnt(input string nm, input logic [15:0] ev, input logic [15:0] g);
    num_checks++;
    if (g !== ev)
    begin
      fails++;
      $display("BAD %s exp %0h got %0h", nm, ev, g);
    end
  endtask : chk_cnt
  // k: 0 closing flag, 1 crc done, 2 control field, 3 abort done
  task tx_evt(input int k, input lfc_frame_type_t t);
    @(posedge clk);
    tx_frame_type <= t;
    tx_end_flag <= (k == 0);
    tx_crc_done <= (k == 1);
    tx_ctl_field <= (k == 2);
    tx_abort_done <= (k == 3);
    @(posedge clk);
    {tx_end_flag, tx_crc_done, tx_ctl_field, tx_abort_done} <= 4'h0;
    #1;
  endtask : tx_evt
  // k: 0 closing flag, 1 control field
  task rx_evt(input int k, input lfc_frame_type_t t, input logic v);
    @(posedge clk);
    rx_frame_type <= t;
    rx_frame_valid <= v;
    rx_end_flag <= (k == 0);
    rx_ctl_field <= (k == 1);
    @(posedge clk);
    {rx_end_flag, rx_ctl_field} <= 2'h0;
    #1;
  endtask : rx_evt
  task go(input lfc_port_state_t s);
    @(posedge clk);
    port_state <= s;
    @(posedge clk);
    #1;
  endtask : go
  task slots(input int n);
    @(posedge clk);
    tx_char_slot <= 1'b1;
    repeat (n) @(posedge clk);
    tx_char_slot <= 1'b0;
    #1;
  endtask : slots
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task peer(input lfc_char_t ch, input int n, input bit cut);
    u_peer.send(ch, n, cut);
    #1;
  endtask : peer
  task wrap_up;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // whole run is about 16k cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial
  begin
    {rst_n, long_reach, rx_ctl_field, rx_end_flag, tx_char_slot, tx_ctl_field} = 6'h0;
    {tx_crc_done, tx_end_flag, tx_abort_done, tx_originated, rx_buf_free} = 5'h0;
    {token_held, forward_pending, have_app_frames, rx_frame_valid} = 4'h1;
    {busy_link_quota, idle_link_quota, xfers_outstanding} = 22'h0;
    port_state = LFC_PS_DISABLED;
    rx_frame_type = LFC_FT_APPLICATION;
    tx_frame_type = LFC_FT_APPLICATION;
    {fails, num_checks, n_rel, n_perr, n_aerr, n_abort, r} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // pacing
    go(LFC_PS_ENABLED);
    chk_cnt("rr_out", 16'h1, 16'(rr_outstanding_count));
    chk_cnt("rr_owed", 16'h1, 16'(rr_owed_count));
    chk_bit("start", 1'b0, may_start_frame);
    chk_bit("start_ctl", 1'b1, may_start_control);
    go(LFC_PS_READY);
    chk_bit("start", 1'b0, may_start_frame);
    peer(LFC_CH_RR, 2, 1'b0);
    chk_cnt("rr_out", 16'h0, 16'(rr_outstanding_count));
    chk_bit("start", 1'b1, may_start_frame);
    tx_evt(2, LFC_FT_APPLICATION);
    tx_evt(2, LFC_FT_CTL_OTHER);
    chk_cnt("rr_out", 16'h1, 16'(rr_outstanding_count));
    rx_evt(1, LFC_FT_PRIVILEGED, 1'b1);
    chk_cnt("rr_owed", 16'h2, 16'(rr_owed_count));
    slots(2);
    chk_cnt("rr_chars", 16'h0, 16'(rr_chars));
    @(posedge clk);
    rx_buf_free <= 1'b1;
    slots(4);
    chk_cnt("rr_chars", 16'h4, 16'(rr_chars));
    chk_cnt("rr_owed", 16'h0, 16'(rr_owed_count));
    // acknowledgment of sent frames, per frame type
    for (i = 0; i < 7; i++)
    begin
      ft = lfc_frame_type_t'(i);
      e = (ft inside {LFC_FT_CTL_TOTAL_RESET, LFC_FT_RESERVED, LFC_FT_CTL_ABS_RESET}) ? 0 : 1;
      tx_evt(0, ft);
      chk_cnt("ack_out", 16'(e), 16'(ack_outstanding_count));
      if (e == 1)
      begin
        peer(LFC_CH_ACK, 2, 1'b0);
        r++;
      end
      chk_cnt("ack_out", 16'h0, 16'(ack_outstanding_count));
      chk_cnt("release", 16'(r), 16'(n_rel));
    end
    // owed acknowledgments in Ready and Check
    e = 0;
    for (i = 0; i < 7; i++)
    begin
      ft = lfc_frame_type_t'(i);
      rx_evt(0, ft, 1'b1);
      e += (ft inside {LFC_FT_CTL_TOTAL_RESET, LFC_FT_RESERVED, LFC_FT_CTL_ABS_RESET}) ? 0 : 1;
    end
    rx_evt(0, LFC_FT_APPLICATION, 1'b0);
    chk_cnt("ack_owed", 16'(e), 16'(ack_owed_count));
    go(LFC_PS_CHECK);
    for (i = 0; i < 7; i++)
      rx_evt(0, lfc_frame_type_t'(i), 1'b1);
    chk_cnt("ack_owed", 16'(e + 1), 16'(ack_owed_count));
    go(LFC_PS_READY);
    slots(2 * (e + 1));
    chk_cnt("ack_chars", 16'(2 * (e + 1)), 16'(ack_chars));
    chk_cnt("ack_owed", 16'h0, 16'(ack_owed_count));
    // protocol errors: pair with none outstanding, then a lone ACK
    peer(LFC_CH_ACK, 2, 1'b0);
    chk_cnt("perr", 16'h1, 16'(n_perr));
    peer(LFC_CH_ACK, 1, 1'b1);
    chk_cnt("perr", 16'h2, 16'(n_perr));
    // closing flag held until the ACK pair, then until time-out
    tx_evt(0, LFC_FT_APPLICATION);
    tx_evt(1, LFC_FT_APPLICATION);
    chk_bit("hold", 1'b1, tx_hold_flag);
    peer(LFC_CH_ACK, 2, 1'b0);
    chk_bit("hold", 1'b0, tx_hold_flag);
    tx_evt(0, LFC_FT_APPLICATION);
    tx_evt(1, LFC_FT_APPLICATION);
    wt(3100);
    chk_cnt("aerr", 16'h0, 16'(n_aerr));
    chk_bit("hold", 1'b1, tx_hold_flag);
    wt(40);
    chk_cnt("aerr", 16'h1, 16'(n_aerr));
    chk_cnt("abort", 16'h1, 16'(n_abort));
    rx_evt(0, LFC_FT_APPLICATION, 1'b1);
    go(LFC_PS_DISABLED);
    chk_cnt("ack_out", 16'h0, 16'(ack_outstanding_count));
    chk_cnt("ack_owed", 16'h0, 16'(ack_owed_count));
    chk_bit("start_ctl", 1'b0, may_start_control);
    // long-reach time-out
    @(posedge clk);
    long_reach <= 1'b1;
    go(LFC_PS_READY);
    tx_evt(0, LFC_FT_APPLICATION);
    wt(12400);
    chk_cnt("aerr", 16'h1, 16'(n_aerr));
    wt(150);
    chk_cnt("aerr", 16'h2, 16'(n_aerr));
    go(LFC_PS_DISABLED);
    // fairness: busy threshold 1 x 2, idle threshold 3 x 2
    @(posedge clk);
    {busy_link_quota, idle_link_quota, xfers_outstanding} <= {8'h01, 8'h03, 6'h02};
    {tx_originated, token_held, have_app_frames, forward_pending} <= 4'hF;
    go(LFC_PS_READY);
    tx_evt(0, LFC_FT_APPLICATION);
    chk_cnt("orig", 16'h1, origination_counter);
    chk_bit("sat", 1'b0, satisfied);
    chk_bit("may_orig", 1'b1, may_originate);
    chk_bit("tok_rel", 1'b0, token_release);
    tx_evt(3, LFC_FT_APPLICATION);
    chk_cnt("orig", 16'h1, origination_counter);
    tx_evt(0, LFC_FT_APPLICATION);
    chk_bit("sat", 1'b1, satisfied);
    chk_bit("tok_rel", 1'b1, token_release);
    @(posedge clk);
    {token_held, forward_pending} <= 2'h0;
    #1;
    chk_cnt("orig", 16'h0, origination_counter);
    chk_bit("may_orig", 1'b1, may_originate);
    @(posedge clk);
    {token_held, have_app_frames} <= 2'h2;
    #1;
    chk_bit("sat", 1'b1, satisfied);
    @(posedge clk);
    {token_held, have_app_frames} <= 2'h1;
    for (i = 0; i < 5; i++)
      tx_evt(0, LFC_FT_APPLICATION);
    chk_bit("may_orig", 1'b1, may_originate);
    tx_evt(0, LFC_FT_APPLICATION);
    chk_bit("may_orig", 1'b0, may_originate);
    chk_cnt("orig", 16'h6, origination_counter);
    wrap_up();
  end
endmodule : link_flow_control_fairness_tb
